/* src/sssup_pkg.sv */
package sssup_pkg;
   // register byte offsets
   localparam logic [7:0] SSSUP_OFS_ALARM = 8'h00; // alarm_status_word
   localparam logic [7:0] SSSUP_OFS_ALARM2 = 8'h04; // alarm_status_word_two
   localparam logic [7:0] SSSUP_OFS_WARN = 8'h08; // warning_status_word
   localparam logic [7:0] SSSUP_OFS_WARN2 = 8'h0c; // warning_status_word_two
   localparam logic [7:0] SSSUP_OFS_CTRL = 8'h10; // mode and reset request
   localparam logic [7:0] SSSUP_OFS_DFUNC = 8'h14; // input function codes
   localparam logic [7:0] SSSUP_OFS_IRQ_ST = 8'h18; // sticky events, write 1 clears
   localparam logic [7:0] SSSUP_OFS_IRQ_MSK = 8'h1c; // event mask
   localparam logic [7:0] SSSUP_OFS_STATE = 8'h20; // live levels
   // status word bit positions
   localparam int SSSUP_BIT_EV = 30; // safe-stop event bit in every word
   localparam int SSSUP_BIT_DANGER = 31; // dangerous failure in word two
   // control fields
   localparam int SSSUP_CTRL_RST_BIT = 8; // write 1 requests a reset
   localparam logic [3:0] SSSUP_MODE_RESET = 4'h1; // default mode
   localparam int SSSUP_FUNC_W = 8; // width of one function code
   // input function codes
   localparam logic [7:0] SSSUP_FUNC_NOP = 8'h00; // no operation
   localparam logic [7:0] SSSUP_FUNC_RESET = 8'h01; // reset request
   localparam logic [7:0] SSSUP_FUNC_ORIGIN = 8'h50; // thermistor origin (80)
   // interrupt status bits
   localparam int SSSUP_IRQ_A68 = 0;
   localparam int SSSUP_IRQ_A71 = 1;
   localparam int SSSUP_IRQ_A72 = 2;
   localparam int SSSUP_IRQ_W68 = 3;
   localparam int SSSUP_IRQ_W71 = 4;
   localparam int SSSUP_IRQ_REJ = 5; // refused mode write
   localparam int SSSUP_IRQ_W = 6;
   // how a source reacts to safe stop
   typedef enum logic [1:0] {
      SSSUP_K_NONE = 2'b00,
      SSSUP_K_ALARM = 2'b01,
      SSSUP_K_WARN = 2'b10
   } sssup_kind_type;

   // mode -> {thermistor kind, relay kind}; none/none marks mode 0 and unused codes
   function automatic logic [3:0] sssup_mode_kinds(input logic [3:0] mode);
      logic [3:0] k;
      k = {SSSUP_K_NONE, SSSUP_K_NONE};
      unique case (mode)
         4'h1: k = {SSSUP_K_NONE, SSSUP_K_ALARM};
         4'h3: k = {SSSUP_K_NONE, SSSUP_K_WARN};
         4'h4: k = {SSSUP_K_ALARM, SSSUP_K_NONE};
         4'h5: k = {SSSUP_K_WARN, SSSUP_K_NONE};
         4'h6: k = {SSSUP_K_ALARM, SSSUP_K_ALARM};
         4'h7: k = {SSSUP_K_WARN, SSSUP_K_WARN};
         4'h8: k = {SSSUP_K_ALARM, SSSUP_K_WARN};
         4'h9: k = {SSSUP_K_WARN, SSSUP_K_ALARM};
         default: k = {SSSUP_K_NONE, SSSUP_K_NONE};
      endcase
      return k;
   endfunction : sssup_mode_kinds
endpackage : sssup_pkg

/* src/sssup_din_decode.sv */
`timescale 1ns/1ns
module sssup_din_decode
   import sssup_pkg::*;
#(
   parameter int N_DIN = 2 // number of digital input lines
) (
   input wire logic sys_clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic [N_DIN-1:0] din_level, // digital_input_line levels
   input wire logic [N_DIN*SSSUP_FUNC_W-1:0] din_func, // function code per line
   output logic origin_q, // any origin-coded line high
   output logic reset_req_q // one-cycle pulse on a reset line rising
);
   logic [N_DIN-1:0] is_org; // line coded as thermistor origin and high
   logic [N_DIN-1:0] is_rst; // line coded as reset and high
   logic [N_DIN-1:0] rst_prev_q; // previous reset level per line

   // per-line decode of the function code
   for (genvar i = 0; i < N_DIN; i++) begin : g_line
      assign is_org[i] = din_level[i] &&
         (din_func[i*SSSUP_FUNC_W +: SSSUP_FUNC_W] == SSSUP_FUNC_ORIGIN);
      assign is_rst[i] = din_level[i] &&
         (din_func[i*SSSUP_FUNC_W +: SSSUP_FUNC_W] == SSSUP_FUNC_RESET);
   end

   // edge detect so that a held input cannot clear later alarms
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rst_prev_q <= '0;
         reset_req_q <= 1'b0;
         origin_q <= 1'b0;
      end else begin
         rst_prev_q <= is_rst;
         reset_req_q <= |(is_rst & ~rst_prev_q);
         origin_q <= |is_org;
      end
   end
endmodule : sssup_din_decode

/* src/sssup_supervisor.sv */
`timescale 1ns/1ns
// Functional notes
// - mode 1 coasts, alarm held until reset
// - mode 3 coasts, resumes when input returns
// - modes 4-9 selectable only with card present
// - mode 5 resumes unless origin input high
// - mode 7 warns both sources, origin blocks resume
// - modes 1 and 3-9 map sources to alarm/warning
// - modes 8/9 mix latched alarm, clearing warning
// - warnings resume when stop and origin clear
// - alarms cleared only by explicit reset request
// - input codes: 0 none, 1 reset, 80 origin
// - origin without safe stop trips alarm 72 in modes 4-9
// - alarms 68/71/72 never auto reset
// - status words bits 30/31 flag events
// - alarm 68 needs input restored before reset
// - alarm 71 needs input and origin clear
// - thermistor trip shown, latched until reset for alarm 71, clears with warning 71
module sssup_supervisor
   import sssup_pkg::*;
#(
   parameter int N_DIN = 2 // digital input lines, 1 to 4
) (
   input wire logic sys_clk, // 50 MHz system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic safe_stop_in, // safe-stop terminal, high = run allowed
   input wire logic [N_DIN-1:0] din_level, // digital_input_line levels
   input wire logic card_present, // thermistor option card detected
   input wire logic reset_key, // local_operator_panel reset key
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   output logic coast, // motor coast command
   output logic trip_display, // thermistor trip indicator for the panel
   output logic irq // level interrupt
);
   if (N_DIN < 1 || N_DIN > 4) begin : g_bad_n
      $error("N_DIN must be 1 to 4");
   end

   // every register here resets synchronously with srst; nothing is kept
   // across a reset, so an alarm 72 does not survive one either
   // software state
   logic [3:0] mode_q; // selected safe-stop mode
   logic [N_DIN*SSSUP_FUNC_W-1:0] dfunc_q; // function code per input
   logic bus_rst_q; // reset request written over the bus
   logic key_prev_q; // previous reset key level
   logic [SSSUP_IRQ_W-1:0] irq_st_q; // sticky events
   logic [SSSUP_IRQ_W-1:0] irq_msk_q; // event enables
   logic [31:0] rdata_q; // read data register
   // alarms and warnings are separate flops so that one source can latch
   // while the other clears itself in the mixed modes
   // event latches
   logic a68_q; // safe_stop_alarm_event
   logic a71_q; // thermistor_stop_alarm_event
   logic a72_q; // dangerous_failure_alarm
   logic w68_q; // safe_stop_warning_event
   logic w71_q; // thermistor_stop_warning_event
   logic coast_q; // coast command register
   logic disp_q; // thermistor trip display
   logic irq_q; // interrupt register
   // decoded inputs
   logic origin; // thermistor_origin_indicator via an input line
   logic din_rst; // reset pulse from an input line
   logic rst_req; // any reset request this cycle
   logic key_rise; // reset key pressed
   logic [1:0] tk; // thermistor source kind
   logic [1:0] rk; // relay source kind
   logic ss_off; // safe stop active
   logic use_therm; // event is charged to the thermistor card
   logic origin_eff; // origin counts only in thermistor modes
   logic resume_ok; // stop and origin both released
   logic bad_levels; // inconsistent levels
   logic set_a68, set_a71, set_w68, set_w71; // event raise terms
   logic [SSSUP_IRQ_W-1:0] ev_rise; // new events for interrupt
   logic wr_ctrl; // control write this cycle
   logic [3:0] wmode; // mode field being written
   logic mode_ok; // written mode may be accepted

   // function codes and origin decode
   sssup_din_decode #(
      .N_DIN(N_DIN)
   ) u_din (
      .sys_clk(sys_clk),
      .srst(srst),
      .din_level(din_level),
      .din_func(dfunc_q),
      .origin_q(origin),
      .reset_req_q(din_rst)
   );

   // source kinds for the current mode
   assign {tk, rk} = sssup_mode_kinds(mode_q);

   // the card's output is the terminal; low means stop requested
   assign ss_off = !safe_stop_in;
   // limitation: a trip whose origin line comes late is charged to the
   // relay chain until the origin level arrives
   // with both sources wired, the origin input says which one tripped
   assign use_therm = (tk != SSSUP_K_NONE) && ((rk == SSSUP_K_NONE) || origin);
   // origin only matters in the thermistor modes; in modes 1 and 3 an
   // input coded 80 is ignored
   assign origin_eff = origin && (tk != SSSUP_K_NONE);
   assign resume_ok = safe_stop_in && !origin_eff;
   assign bad_levels = origin_eff && safe_stop_in;

   // a stop seen in mode 0 raises nothing and never coasts the motor
   // event raise terms; modes 8/9 split alarm and warning per source
   assign set_a68 = ss_off && !use_therm && (rk == SSSUP_K_ALARM);
   assign set_w68 = ss_off && !use_therm && (rk == SSSUP_K_WARN);
   assign set_a71 = ss_off && use_therm && (tk == SSSUP_K_ALARM);
   assign set_w71 = ss_off && use_therm && (tk == SSSUP_K_WARN);

   // the key is edge detected here and input lines in the decoder, so a
   // stuck button or line cannot wipe out a trip that comes later
   // reset sources: key edge, bus pulse, input-line edge
   assign key_rise = reset_key && !key_prev_q;
   assign rst_req = key_rise || bus_rst_q || din_rst;

   // a refused write leaves the mode alone and flags the event (its reset bit still acts), so a
   // drive without the card cannot select a mode it cannot serve; the card is checked only on the write
   // mode write acceptance
   assign wr_ctrl = reg_wr && (reg_addr == SSSUP_OFS_CTRL);
   assign wmode = reg_wdata[3:0];
   // codes 4..9 need a thermistor kind, so they need the card
   always_comb begin
      mode_ok = (wmode == 4'h0) || (sssup_mode_kinds(wmode) != 4'h0);
      if (sssup_mode_kinds(wmode) >= {SSSUP_K_ALARM, 2'b00} && !card_present) begin
         mode_ok = 1'b0;
      end
   end

   // mode register and function codes
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_q <= SSSUP_MODE_RESET;
         dfunc_q <= '0;
      end else begin
         if (wr_ctrl && mode_ok) begin
            mode_q <= wmode;
         end
         if (reg_wr && reg_addr == SSSUP_OFS_DFUNC) begin
            dfunc_q <= reg_wdata[N_DIN*SSSUP_FUNC_W-1:0];
         end
      end
   end

   // reset request capture
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_rst_q <= 1'b0;
         key_prev_q <= 1'b0;
      end else begin
         bus_rst_q <= wr_ctrl && reg_wdata[SSSUP_CTRL_RST_BIT];
         key_prev_q <= reset_key;
      end
   end

   // alarms latch; only a reset request with released levels clears them.
   // raise terms are level based, so a reset while stop is held is void.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         a68_q <= 1'b0;
         a71_q <= 1'b0;
         a72_q <= 1'b0;
      end else begin
         a68_q <= set_a68 || (a68_q && !(rst_req && safe_stop_in));
         a71_q <= set_a71 || (a71_q && !(rst_req && resume_ok));
         a72_q <= bad_levels || (a72_q && !rst_req);
      end
   end

   // warnings clear themselves once stop and origin are gone
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         w68_q <= 1'b0;
         w71_q <= 1'b0;
      end else begin
         w68_q <= set_w68 || (w68_q && !resume_ok);
         w71_q <= set_w71 || (w71_q && !resume_ok);
      end
   end

   // the raise terms feed coast directly so the command is not a cycle
   // behind the latch; the price is a wider or in front of the flop
   // coast from the first sampled stop until resume conditions hold
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         coast_q <= 1'b0;
         disp_q <= 1'b0;
      end else begin
         coast_q <= set_a68 || set_a71 || set_w68 || set_w71 || bad_levels ||
            a68_q || a71_q || a72_q || (w68_q && !resume_ok) ||
            (w71_q && !resume_ok);
         disp_q <= set_a71 || set_w71 || a71_q || w71_q;
      end
   end

   // an event already latched does not count again, so a held stop
   // raises one interrupt and not one per cycle
   // interrupt events are rising edges of the latches, plus refused mode writes
   assign ev_rise[SSSUP_IRQ_A68] = set_a68 && !a68_q;
   assign ev_rise[SSSUP_IRQ_A71] = set_a71 && !a71_q;
   assign ev_rise[SSSUP_IRQ_A72] = bad_levels && !a72_q;
   assign ev_rise[SSSUP_IRQ_W68] = set_w68 && !w68_q;
   assign ev_rise[SSSUP_IRQ_W71] = set_w71 && !w71_q;
   assign ev_rise[SSSUP_IRQ_REJ] = wr_ctrl && !mode_ok;

   // sticky status: a new event wins over a write-one clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_st_q <= '0;
         irq_msk_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == SSSUP_OFS_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~reg_wdata[SSSUP_IRQ_W-1:0]) | ev_rise;
         end else begin
            irq_st_q <= irq_st_q | ev_rise;
         end
         if (reg_wr && reg_addr == SSSUP_OFS_IRQ_MSK) begin
            irq_msk_q <= reg_wdata[SSSUP_IRQ_W-1:0];
         end
         irq_q <= |(irq_st_q & irq_msk_q);
      end
   end

   // reads have no side effects; sticky bits clear only by writes
   // read data register; unmapped addresses read zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         rdata_q <= '0;
         unique case (reg_addr)
            SSSUP_OFS_ALARM: rdata_q[SSSUP_BIT_EV] <= a68_q;
            SSSUP_OFS_ALARM2: begin
               rdata_q[SSSUP_BIT_EV] <= a71_q;
               rdata_q[SSSUP_BIT_DANGER] <= a72_q;
            end
            SSSUP_OFS_WARN: rdata_q[SSSUP_BIT_EV] <= w68_q;
            SSSUP_OFS_WARN2: rdata_q[SSSUP_BIT_EV] <= w71_q;
            SSSUP_OFS_CTRL: rdata_q[3:0] <= mode_q;
            SSSUP_OFS_DFUNC: rdata_q[N_DIN*SSSUP_FUNC_W-1:0] <= dfunc_q;
            SSSUP_OFS_IRQ_ST: rdata_q[SSSUP_IRQ_W-1:0] <= irq_st_q;
            SSSUP_OFS_IRQ_MSK: rdata_q[SSSUP_IRQ_W-1:0] <= irq_msk_q;
            SSSUP_OFS_STATE: rdata_q[3:0] <= {card_present, origin, safe_stop_in, coast_q};
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0; // data stand only in the cycle after the strobe
      end
   end

   assign reg_rdata = rdata_q;
   assign coast = coast_q;
   assign trip_display = disp_q;
   assign irq = irq_q;

   // checks; every latch is a flop, so consequents look one edge after
   // the cause with |=> against the register they expect
   // checks
   AST_ALARM_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      a68_q && !rst_req |=> a68_q)
      else $error("alarm 68 cleared without reset");
   AST_COAST_ON_STOP: assert property (@(posedge sys_clk) disable iff (srst)
      (set_a68 || set_w68 || set_a71 || set_w71) |=> coast_q)
      else $error("coast missing after stop");
   AST_MODE3_RESUME: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h3 && w68_q && safe_stop_in ##1 safe_stop_in |-> !w68_q)
      else $error("mode 3 did not resume");
   AST_MODE_GATE: assert property (@(posedge sys_clk) disable iff (srst)
      wr_ctrl && !card_present && wmode >= 4'h4 |=> mode_q == $past(mode_q))
      else $error("thermistor mode taken without card");
   AST_ORIGIN_BLOCKS: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h5 && w71_q && origin |=> w71_q)
      else $error("warning 71 cleared while origin high");
   AST_DANGER: assert property (@(posedge sys_clk) disable iff (srst)
      tk != SSSUP_K_NONE && origin && safe_stop_in |=> a72_q ##1 coast_q)
      else $error("alarm 72 not raised");
   AST_A68_NEEDS_INPUT: assert property (@(posedge sys_clk) disable iff (srst)
      a68_q && !safe_stop_in |=> a68_q)
      else $error("alarm 68 left with input off");
   AST_A71_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
      a71_q && rst_req && resume_ok && !set_a71 |=> !a71_q)
      else $error("alarm 71 not cleared by reset");
   AST_WORD_BIT: assert property (@(posedge sys_clk) disable iff (srst)
      reg_rd && reg_addr == SSSUP_OFS_ALARM2 |=> reg_rdata[31] == $past(a72_q))
      else $error("alarm word two bit 31 wrong");
   AST_KEY_EDGE: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(reset_key) && a68_q && safe_stop_in |=> !a68_q)
      else $error("key press did not clear alarm 68");

   // alarms hold without a reset and clear with one once levels are back
   AST_A71_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      a71_q && !rst_req |=> a71_q)
      else $error("alarm 71 cleared without reset");
   AST_A72_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      a72_q && !rst_req |=> a72_q)
      else $error("alarm 72 cleared without reset");
   AST_A68_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
      a68_q && rst_req && safe_stop_in |=> !a68_q)
      else $error("alarm 68 not cleared by reset");

   // warnings release on their own; origin blocks them in thermistor modes
   AST_W68_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
      w68_q && resume_ok |=> !w68_q)
      else $error("warning 68 held after release");
   AST_W71_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
      w71_q && resume_ok |=> !w71_q)
      else $error("warning 71 held after release");
   AST_MODE7_BLOCK: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h7 && w71_q && origin |=> w71_q)
      else $error("mode 7 warning cleared while origin high");

   // mode table: which source raises what
   AST_MODE0_QUIET: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h0 && !(a68_q || a71_q || a72_q || w68_q || w71_q) |=> !coast_q)
      else $error("mode 0 coasted");
   AST_MODE1_ALARM: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h1 && !safe_stop_in |=> a68_q && coast_q)
      else $error("mode 1 stop without alarm 68");
   AST_THERM_ALARM: assert property (@(posedge sys_clk) disable iff (srst)
      (mode_q == 4'h6 || mode_q == 4'h8) && !safe_stop_in && origin |=> a71_q)
      else $error("thermistor stop without alarm 71");
   AST_RELAY_WARN: assert property (@(posedge sys_clk) disable iff (srst)
      mode_q == 4'h8 && !safe_stop_in && !origin |=> w68_q)
      else $error("mode 8 relay stop without warning 68");

   // outputs and reset sources
   AST_TRIP_SHOWN: assert property (@(posedge sys_clk) disable iff (srst)
      a71_q || w71_q |=> disp_q)
      else $error("thermistor trip not shown");
   AST_DIN_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
      din_rst |=> !din_rst)
      else $error("input reset pulse longer than one cycle");
endmodule : sssup_supervisor

/* sim/sssup_card_model.sv */
`timescale 1ns/1ns
// thermistor card plus the relay chain ahead of the safe-stop terminal
module sssup_card_model (
   input wire logic sys_clk, // system clock
   input wire logic hot, // overtemperature or sensor short
   input wire logic relay_open, // another safety device opens the chain
   input wire logic fault, // origin raised wrongly, failure test only
   output logic safe_stop, // level seen at the safe-stop terminal
   output logic origin // thermistor_origin_indicator
);
   logic hot_q; // trip delayed one cycle
   logic safe_q; // thermistor_safe_output
   // origin leads the safe output on a trip and drops first on recovery,
   // so the drive never sees the two levels disagree
   always_ff @(posedge sys_clk) begin
      hot_q <= hot;
      origin <= hot | fault;
      safe_q <= ~hot_q;
   end
   // the card is first in the chain: any open relay also stops the drive
   assign safe_stop = safe_q & ~relay_open;
endmodule : sssup_card_model

/* sim/safe_stop_alarm_supervisor_test.sv */
`timescale 1ns/1ns
module safe_stop_alarm_supervisor_test;
   import sssup_pkg::*;
   localparam logic [31:0] EV = 32'h40000000; // bit 30 of any word
   localparam logic [3:0] THERM_A = 4'b0101; // modes 6..9, thermistor alarm
   localparam logic [3:0] RELAY_A = 4'b1001; // modes 6..9, relay alarm
   logic sys_clk, srst, hot, relay_open, fault, safe_stop, origin;
   logic din_rst, card_present, reset_key, reg_wr, reg_rd;
   logic coast, trip_display, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int bad_count;
   int comparisons;
   logic ta, ra;
   sssup_card_model u_card (.sys_clk(sys_clk), .hot(hot), .relay_open(relay_open),
      .fault(fault), .safe_stop(safe_stop), .origin(origin));
   // input 0 carries the card origin line, input 1 is a reset line
   sssup_supervisor #(.N_DIN(2)) u_dut (.sys_clk(sys_clk), .srst(srst),
      .safe_stop_in(safe_stop), .din_level({din_rst, origin}),
      .card_present(card_present), .reset_key(reset_key), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .coast(coast), .trip_display(trip_display), .irq(irq));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // compare one value
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      check(reg_rdata, exp);
   endtask : rd
   // all four status words
   task automatic words(input logic [31:0] a, a2, w, w2);
      rd(SSSUP_OFS_ALARM, a);
      rd(SSSUP_OFS_ALARM2, a2);
      rd(SSSUP_OFS_WARN, w);
      rd(SSSUP_OFS_WARN2, w2);
   endtask : words
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle
   // panel key press, one cycle
   task automatic press;
      @(posedge sys_clk);
      reset_key <= 1'b1;
      @(posedge sys_clk);
      reset_key <= 1'b0;
      idle(2);
   endtask : press
   function automatic logic [31:0] sel(input logic b);
      return b ? EV : 32'h00000000;
   endfunction : sel
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   // a hang ends the run as a failure
   initial begin
      idle(8000);
      bad_count++;
      results();
   end
   initial begin
      {srst, hot, relay_open, fault, din_rst, reset_key, reg_wr, reg_rd} = 8'hff;
      {hot, relay_open, fault, din_rst, reset_key, reg_wr, reg_rd} = 7'h00;
      card_present = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      bad_count = 0;
      comparisons = 0;
      idle(10);
      srst <= 1'b0;
      // reset values, unmapped and read-only places
      words(0, 0, 0, 0);
      rd(SSSUP_OFS_CTRL, 32'h1);
      rd(SSSUP_OFS_STATE, 32'ha);
      rd(8'h40, 32'h0);
      wr(SSSUP_OFS_ALARM, 32'hffffffff);
      rd(SSSUP_OFS_ALARM, 32'h0);
      $display("test reset done");
      // mode 1: latched alarm, early reset ignored, interrupt path
      wr(SSSUP_OFS_IRQ_MSK, 32'h1);
      relay_open <= 1'b1;
      idle(3);
      check(coast, 1'b1);
      words(EV, 0, 0, 0);
      check(irq, 1'b1);
      press();
      rd(SSSUP_OFS_ALARM, EV);
      relay_open <= 1'b0;
      idle(4);
      check(coast, 1'b1);
      din_rst <= 1'b1;
      idle(3);
      din_rst <= 1'b0;
      rd(SSSUP_OFS_ALARM, EV);
      press();
      rd(SSSUP_OFS_ALARM, 32'h0);
      check(coast, 1'b0);
      wr(SSSUP_OFS_IRQ_ST, 32'h1);
      idle(2);
      check(irq, 1'b0);
      $display("test alarm done");
      // mode 3: warning clears by itself
      wr(SSSUP_OFS_CTRL, 32'h3);
      relay_open <= 1'b1;
      idle(3);
      words(0, 0, EV, 0);
      check(coast, 1'b1);
      relay_open <= 1'b0;
      idle(4);
      check(coast, 1'b0);
      words(0, 0, 0, 0);
      wr(SSSUP_OFS_IRQ_ST, 32'h3f);
      $display("test warning done");
      // thermistor modes refused without the card; event is masked
      card_present <= 1'b0;
      wr(SSSUP_OFS_CTRL, 32'h4);
      rd(SSSUP_OFS_CTRL, 32'h3);
      rd(SSSUP_OFS_IRQ_ST, 32'h20);
      check(irq, 1'b0);
      card_present <= 1'b1;
      wr(SSSUP_OFS_CTRL, 32'h4);
      rd(SSSUP_OFS_CTRL, 32'h4);
      $display("test refusal done");
      // mode 4 with origin and reset input lines; held reset line
      wr(SSSUP_OFS_DFUNC, 32'h0150);
      hot <= 1'b1;
      idle(4);
      words(0, EV, 0, 0);
      check(trip_display, 1'b1);
      din_rst <= 1'b1;
      idle(3);
      din_rst <= 1'b0;
      rd(SSSUP_OFS_ALARM2, EV);
      hot <= 1'b0;
      idle(4);
      rd(SSSUP_OFS_ALARM2, EV);
      din_rst <= 1'b1;
      idle(3);
      rd(SSSUP_OFS_ALARM2, 32'h0);
      hot <= 1'b1;
      idle(4);
      hot <= 1'b0;
      idle(4);
      rd(SSSUP_OFS_ALARM2, EV);
      din_rst <= 1'b0;
      press();
      $display("test input reset done");
      // mode 5: thermistor warning resumes once both lines clear
      wr(SSSUP_OFS_CTRL, 32'h5);
      hot <= 1'b1;
      idle(4);
      words(0, 0, 0, EV);
      hot <= 1'b0;
      idle(5);
      check(coast, 1'b0);
      words(0, 0, 0, 0);
      $display("test mode 5 done");
      // combined modes: each source with its own kind
      for (int m = 6; m <= 9; m++) begin
         wr(SSSUP_OFS_CTRL, 32'(m));
         ta = THERM_A[m-6];
         ra = RELAY_A[m-6];
         hot <= 1'b1;
         idle(4);
         words(0, sel(ta), 0, sel(!ta));
         hot <= 1'b0;
         idle(5);
         words(0, sel(ta), 0, 0);
         press();
         relay_open <= 1'b1;
         idle(4);
         words(sel(ra), 0, sel(!ra), 0);
         relay_open <= 1'b0;
         idle(4);
         words(sel(ra), 0, 0, 0);
         press();
         check(coast, 1'b0);
      end
      $display("test combined modes done");
      // origin high while the terminal allows running
      fault <= 1'b1;
      idle(4);
      rd(SSSUP_OFS_ALARM2, 32'h80000000);
      check(coast, 1'b1);
      fault <= 1'b0;
      idle(3);
      press();
      rd(SSSUP_OFS_ALARM2, 32'h0);
      $display("test dangerous failure done");
      // mode 0 ignores the terminal; code 2 is refused
      wr(SSSUP_OFS_CTRL, 32'h0);
      relay_open <= 1'b1;
      idle(3);
      check(coast, 1'b0);
      words(0, 0, 0, 0);
      relay_open <= 1'b0;
      wr(SSSUP_OFS_CTRL, 32'h2);
      rd(SSSUP_OFS_CTRL, 32'h0);
      // mode 1 again, reset request written over the bus
      wr(SSSUP_OFS_CTRL, 32'h1);
      relay_open <= 1'b1;
      idle(3);
      wr(SSSUP_OFS_CTRL, 32'h101);
      rd(SSSUP_OFS_ALARM, EV);
      relay_open <= 1'b0;
      idle(2);
      wr(SSSUP_OFS_CTRL, 32'h101);
      idle(1);
      rd(SSSUP_OFS_ALARM, 32'h0);
      check(coast, 1'b0);
      $display("test bus reset done");
      results();
   end
endmodule : safe_stop_alarm_supervisor_test
